//--- core/prsc_rx_status.v
`timescale 1ns/1ps
`include "prsc_defs.vh"

module prsc_rx_status (
    input  wire        CLOCK,
    input  wire        RST_N,
    input  wire [15:0] ADR_I,
    input  wire [31:0] DAT_I,
    output reg  [31:0] DAT_O,
    input  wire        WE_I,
    input  wire [3:0]  SEL_I,
    input  wire        CYC_I,
    input  wire        STB_I,
    output reg         ACK_O,
    output reg         IRQ,
    input  wire        RX_BAD_PKT,
    input  wire        RX_DUP_PKT,
    input  wire        RX_PKT_END,
    input  wire [7:0]  RX_PKT_LEN,
    input  wire        RX_ACK_MSG_VALID,
    input  wire [15:0] RX_ACK_MSG,
    input  wire [4:0]  MSG_ID_STORE,
    input  wire        HR_DETECT,
    input  wire [6:0]  HR_BIT_COUNT,
    input  wire        RD_ADVANCE,
    input  wire        FIFO_EMPTY,
    output reg         PKT_DROP,
    output reg         HARD_RESET_VALID,
    output reg  [4:0]  MSG_ID_FORGET,
    output reg  [7:0]  SIZE_LIMIT,
    output reg  [6:0]  DETECT_WINDOW,
    output reg  [6:0]  READ_POINTER,
    output reg         READ_WRAP,
    output reg         AUTO_RESPONSE,
    output reg         AUTO_RETRY,
    output reg         BIST_RX_TEST,
    output reg         SOFTWARE_RESET,
    output reg         PROTOCOL_RESET
);

    // ****************************************************************
    // bus decode
    // ****************************************************************
    wire [13:0] index;
    wire        req;
    wire        wr;
    wire [7:0]  wdata;

    assign index = ADR_I[15:2];
    assign req   = CYC_I & STB_I & ~ACK_O;
    assign wr    = req & WE_I & SEL_I[0];
    assign wdata = DAT_I[7:0];

    wire wr_bad_count;
    wire wr_dup_count;
    wire wr_hr_window;
    wire wr_msg_flags;
    wire wr_size_limit;
    wire wr_read_ptr;
    wire wr_read_ctl;
    wire wr_pkt_status;
    wire wr_irq_status;
    wire wr_irq_mask;
    wire wr_control;
    wire wr_reset_control_register;

    // per-register write strobes, one cycle at the acked access
    assign wr_bad_count  = wr & (index == `PRSC_IDX_BAD_COUNT);
    assign wr_dup_count  = wr & (index == `PRSC_IDX_DUP_COUNT);
    assign wr_hr_window  = wr & (index == `PRSC_IDX_HR_WINDOW);
    assign wr_msg_flags  = wr & (index == `PRSC_IDX_MSG_ID_FLAGS);
    assign wr_size_limit = wr & (index == `PRSC_IDX_SIZE_LIMIT);
    assign wr_read_ptr   = wr & (index == `PRSC_IDX_READ_POINTER);
    assign wr_read_ctl   = wr & (index == `PRSC_IDX_READ_CTL);
    assign wr_pkt_status = wr & (index == `PRSC_IDX_PKT_STATUS);
    assign wr_irq_status = wr & (index == `PRSC_IDX_IRQ_STATUS);
    assign wr_irq_mask   = wr & (index == `PRSC_IDX_IRQ_MASK);
    assign wr_control    = wr & (index == `PRSC_IDX_CONTROL);
    assign wr_reset_control_register  = wr & (index == `PRSC_IDX_RESET_CONTROL_REGISTER);

    // ****************************************************************
    // packet counters
    // ****************************************************************
    wire [7:0] bad_packet_tally;
    wire [7:0] duplicate_packet_tally;
    wire       count_bad;
    wire       count_dup;

    assign count_bad = RX_BAD_PKT & ~BIST_RX_TEST;
    assign count_dup = RX_DUP_PKT & AUTO_RESPONSE;

    // saturating counter, write clears
    prsc_sat_counter #(
        .WIDTH (8)
    ) u_bad_count (
        .clock (CLOCK),
        .rst_n (RST_N),
        .inc   (count_bad),
        .clr   (wr_bad_count),
        .q     (bad_packet_tally)
    );

    // saturating counter, write clears
    prsc_sat_counter #(
        .WIDTH (8)
    ) u_dup_count (
        .clock (CLOCK),
        .rst_n (RST_N),
        .inc   (count_dup),
        .clr   (wr_dup_count),
        .q     (duplicate_packet_tally)
    );

    // ****************************************************************
    // packet checks
    // ****************************************************************
    wire oversize;
    wire dup_event;

    assign oversize  = RX_PKT_END & (RX_PKT_LEN > SIZE_LIMIT);
    assign dup_event = RX_DUP_PKT & AUTO_RESPONSE;

    // drop strobe and hard reset qualification
    always @(posedge CLOCK) begin
        if (!RST_N) begin
            PKT_DROP         <= 1'b0;
            HARD_RESET_VALID <= 1'b0;
        end else begin
            PKT_DROP         <= oversize | dup_event;
            HARD_RESET_VALID <= HR_DETECT & (HR_BIT_COUNT <= DETECT_WINDOW);
        end
    end

    // ****************************************************************
    // packet status and interrupt flags
    // ****************************************************************
    wire [6:0] pkt_set;
    wire [6:0] pkt_status;
    wire [2:0] irq_set;
    wire [2:0] irq_status;
    reg  [2:0] irq_mask;
    wire       debug_event_flag;

    assign pkt_set = {3'h0, oversize, 1'b0, dup_event, 1'b0};
    assign debug_event_flag = bad_packet_tally[7] | duplicate_packet_tally[7];
    assign irq_set = {dup_event, oversize | count_bad, debug_event_flag};

    // write-one-to-clear packet status
    prsc_sticky_bits #(
        .WIDTH (7)
    ) u_pkt_status (
        .clock (CLOCK),
        .rst_n (RST_N),
        .set   (pkt_set),
        .clr   (wr_pkt_status ? wdata[6:0] : 7'h00),
        .q     (pkt_status)
    );

    // write-one-to-clear interrupt status
    prsc_sticky_bits #(
        .WIDTH (3)
    ) u_irq_status (
        .clock (CLOCK),
        .rst_n (RST_N),
        .set   (irq_set),
        .clr   (wr_irq_status ? wdata[2:0] : 3'h0),
        .q     (irq_status)
    );

    // ****************************************************************
    // stored message id flags
    // ****************************************************************
    wire [4:0] message_id_stored_flags;
    wire [4:0] flag_clear;
    wire       reset_command;

    assign reset_command = wr_reset_control_register & (wdata[`PRSC_RST_SOFTWARE] | wdata[`PRSC_RST_PROTOCOL]);
    assign flag_clear    = (wr_msg_flags ? wdata[4:0] : 5'h00) | {5{reset_command}};

    // one flag per sop type
    prsc_sticky_bits #(
        .WIDTH (5)
    ) u_msg_flags (
        .clock (CLOCK),
        .rst_n (RST_N),
        .set   (MSG_ID_STORE),
        .clr   (flag_clear),
        .q     (message_id_stored_flags)
    );

    // forget strobe to the duplicate detector, skipped where a store wins
    always @(posedge CLOCK) begin
        if (!RST_N) begin
            MSG_ID_FORGET <= 5'h00;
        end else begin
            MSG_ID_FORGET <= flag_clear & ~MSG_ID_STORE;
        end
    end

    // ****************************************************************
    // configuration registers
    // ****************************************************************
    reg [15:0] last_ack_message;

    // software-written settings and command pulses
    always @(posedge CLOCK) begin
        if (!RST_N) begin
            DETECT_WINDOW  <= `PRSC_RST_HR_WINDOW;
            SIZE_LIMIT     <= `PRSC_RST_SIZE_LIMIT;
            irq_mask       <= `PRSC_RST_IRQ_MASK;
            AUTO_RESPONSE  <= 1'b0;
            AUTO_RETRY     <= 1'b0;
            BIST_RX_TEST   <= 1'b0;
            SOFTWARE_RESET <= 1'b0;
            PROTOCOL_RESET <= 1'b0;
        end else begin
            if (wr_hr_window) begin
                DETECT_WINDOW <= wdata[6:0];
            end
            if (wr_size_limit) begin
                SIZE_LIMIT <= wdata;
            end
            if (wr_irq_mask) begin
                irq_mask <= wdata[2:0];
            end
            if (wr_control) begin
                AUTO_RESPONSE <= wdata[`PRSC_CTL_AUTO_RESPONSE];
                AUTO_RETRY    <= wdata[`PRSC_CTL_AUTO_RETRY];
                BIST_RX_TEST  <= wdata[`PRSC_CTL_BIST_RX];
            end
            SOFTWARE_RESET <= wr_reset_control_register & wdata[`PRSC_RST_SOFTWARE];
            PROTOCOL_RESET <= wr_reset_control_register & wdata[`PRSC_RST_PROTOCOL];
        end
    end

    // last acknowledge message capture
    always @(posedge CLOCK) begin
        if (!RST_N) begin
            last_ack_message <= `PRSC_RST_ACK_MSG;
        end else if (RX_ACK_MSG_VALID & AUTO_RETRY) begin
            last_ack_message <= RX_ACK_MSG;
        end
    end

    // ****************************************************************
    // receive fifo read pointer
    // ****************************************************************
    reg [6:0] pointer_hold;

    // held value loads on a control write, else hardware advances
    always @(posedge CLOCK) begin
        if (!RST_N) begin
            pointer_hold <= `PRSC_RST_POINTER;
            READ_POINTER <= `PRSC_RST_POINTER;
            READ_WRAP    <= 1'b0;
        end else begin
            if (wr_read_ptr) begin
                pointer_hold <= wdata[6:0];
            end
            if (wr_read_ctl) begin
                READ_POINTER <= pointer_hold;
                READ_WRAP    <= wdata[`PRSC_RDCTL_WRAP];
            end else if (RD_ADVANCE) begin
                READ_POINTER <= READ_POINTER + 7'h01;
                if (READ_POINTER == `PRSC_POINTER_TOP) begin
                    READ_WRAP <= ~READ_WRAP;
                end
            end
        end
    end

    // ****************************************************************
    // read mux and bus answer
    // ****************************************************************
    reg [7:0] rdata;

    // unmapped indices read zero
    always @* begin
        case (index)
            `PRSC_IDX_PKT_STATUS:   rdata = {1'b0, pkt_status};
            `PRSC_IDX_BAD_COUNT:    rdata = bad_packet_tally;
            `PRSC_IDX_DUP_COUNT:    rdata = duplicate_packet_tally;
            `PRSC_IDX_HR_WINDOW:    rdata = {1'b0, DETECT_WINDOW};
            `PRSC_IDX_ACK_HIGH:     rdata = last_ack_message[15:8];
            `PRSC_IDX_ACK_LOW:      rdata = last_ack_message[7:0];
            `PRSC_IDX_MSG_ID_FLAGS: rdata = {3'h0, message_id_stored_flags};
            `PRSC_IDX_SIZE_LIMIT:   rdata = SIZE_LIMIT;
            `PRSC_IDX_READ_POINTER: rdata = {1'b0, READ_POINTER};
            `PRSC_IDX_READ_CTL:     rdata = {FIFO_EMPTY, 5'h00, (READ_POINTER == `PRSC_POINTER_TOP), READ_WRAP};
            `PRSC_IDX_IRQ_STATUS:   rdata = {5'h00, irq_status};
            `PRSC_IDX_IRQ_MASK:     rdata = {5'h00, irq_mask};
            `PRSC_IDX_CONTROL:      rdata = {5'h00, BIST_RX_TEST, AUTO_RETRY, AUTO_RESPONSE};
            default:                rdata = 8'h00;
        endcase
    end

    // ack one cycle after the request, data registered with it
    always @(posedge CLOCK) begin
        if (!RST_N) begin
            ACK_O <= 1'b0;
            DAT_O <= 32'h00000000;
            IRQ   <= 1'b0;
        end else begin
            ACK_O <= req;
            if (req) begin
                DAT_O <= {24'h000000, rdata};
            end
            IRQ <= |(irq_status & irq_mask);
        end
    end

endmodule

//--- core/prsc_defs.vh
`ifndef PRSC_DEFS_VH
`define PRSC_DEFS_VH

// ****************************************************************
// register indices (byte address = index * 4)
// ****************************************************************
`define PRSC_IDX_PKT_STATUS    14'h1a45
`define PRSC_IDX_BAD_COUNT     14'h1a47
`define PRSC_IDX_DUP_COUNT     14'h1a48
`define PRSC_IDX_HR_WINDOW     14'h1a49
`define PRSC_IDX_ACK_HIGH      14'h1a4a
`define PRSC_IDX_ACK_LOW       14'h1a4b
`define PRSC_IDX_MSG_ID_FLAGS  14'h1a4c
`define PRSC_IDX_SIZE_LIMIT    14'h1a4d
`define PRSC_IDX_READ_POINTER  14'h1a50
`define PRSC_IDX_READ_CTL      14'h1a51
`define PRSC_IDX_IRQ_STATUS    14'h1a58
`define PRSC_IDX_IRQ_MASK      14'h1a59
`define PRSC_IDX_CONTROL       14'h1a5a
`define PRSC_IDX_RESET_CONTROL_REGISTER     14'h1a5b

// ****************************************************************
// reset values
// ****************************************************************
`define PRSC_RST_COUNT         8'h00
`define PRSC_RST_HR_WINDOW     7'h5e
`define PRSC_RST_ACK_MSG       16'h0000
`define PRSC_RST_SIZE_LIMIT    8'h22
`define PRSC_RST_POINTER       7'h00
`define PRSC_RST_IRQ_MASK      3'h0
`define PRSC_RST_CONTROL       3'h0

// ****************************************************************
// field positions
// ****************************************************************
`define PRSC_PKT_DUPLICATE     1
`define PRSC_PKT_OVERSIZE      3
`define PRSC_IRQ_DEBUG_EVENT   0
`define PRSC_IRQ_BAD_PKT       1
`define PRSC_IRQ_PKT_DROPPED   2
`define PRSC_CTL_AUTO_RESPONSE 0
`define PRSC_CTL_AUTO_RETRY    1
`define PRSC_CTL_BIST_RX       2
`define PRSC_RST_SOFTWARE      0
`define PRSC_RST_PROTOCOL      1
`define PRSC_RDCTL_WRAP        0
`define PRSC_RDCTL_AT_TOP      1
`define PRSC_RDCTL_EMPTY       7
`define PRSC_POINTER_TOP       7'h7f

`endif

//--- core/prsc_sat_counter.v
`timescale 1ns/1ps

// ****************************************************************
// saturating event counter, clear by write
// ****************************************************************
module prsc_sat_counter #(
    parameter WIDTH = 8
) (
    input  wire             clock,
    input  wire             rst_n,
    input  wire             inc,
    input  wire             clr,
    output reg  [WIDTH-1:0] q
);

    wire [WIDTH-1:0] max_val;
    reg  [WIDTH-1:0] next_q;

    assign max_val = {WIDTH{1'b1}};

    // clear zeroes, an event in the same cycle still counts
    always @* begin
        next_q = q;
        if (clr) begin
            next_q = {WIDTH{1'b0}};
        end
        if (inc) begin
            if (clr) begin
                next_q = {{(WIDTH-1){1'b0}}, 1'b1};
            end else if (q != max_val) begin
                next_q = q + {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

    // state update
    always @(posedge clock) begin
        if (!rst_n) begin
            q <= {WIDTH{1'b0}};
        end else begin
            q <= next_q;
        end
    end

endmodule

//--- core/prsc_sticky_bits.v
`timescale 1ns/1ps

// ****************************************************************
// sticky flags, set by hardware, set wins over clear
// ****************************************************************
module prsc_sticky_bits #(
    parameter WIDTH = 3
) (
    input  wire             clock,
    input  wire             rst_n,
    input  wire [WIDTH-1:0] set,
    input  wire [WIDTH-1:0] clr,
    output reg  [WIDTH-1:0] q
);

    genvar i;

    // one flop per flag
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            always @(posedge clock) begin
                if (!rst_n) begin
                    q[i] <= 1'b0;
                end else if (set[i]) begin
                    q[i] <= 1'b1;
                end else if (clr[i]) begin
                    q[i] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule

//--- tb/prsc_rx_status_chk.sv
`timescale 1ns/1ps
`include "prsc_defs.vh"

// ****************************************************************
// port checker for the receive status bank
// ****************************************************************
module prsc_rx_status_chk (
    input logic        CLOCK,
    input logic        RST_N,
    input logic [15:0] ADR_I,
    input logic [31:0] DAT_I,
    input logic        WE_I,
    input logic [3:0]  SEL_I,
    input logic        CYC_I,
    input logic        STB_I,
    input logic        ACK_O,
    input logic        RX_DUP_PKT,
    input logic        RX_PKT_END,
    input logic [7:0]  RX_PKT_LEN,
    input logic [4:0]  MSG_ID_STORE,
    input logic        HR_DETECT,
    input logic [6:0]  HR_BIT_COUNT,
    input logic        RD_ADVANCE,
    input logic        PKT_DROP,
    input logic        HARD_RESET_VALID,
    input logic [4:0]  MSG_ID_FORGET,
    input logic [7:0]  SIZE_LIMIT,
    input logic [6:0]  DETECT_WINDOW,
    input logic [6:0]  READ_POINTER,
    input logic        AUTO_RESPONSE,
    input logic        AUTO_RETRY,
    input logic        BIST_RX_TEST,
    input logic        SOFTWARE_RESET,
    input logic        PROTOCOL_RESET
);
    // bus request decode
    wire        take  = CYC_I && STB_I && !ACK_O;
    wire        wtake = take && WE_I && SEL_I[0];
    wire [13:0] ix    = ADR_I[15:2];
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);
    ack_resp_a: assert property (take |=> ACK_O ##1 !ACK_O)
        else $error("bus request not answered once");
    hr_valid_a: assert property (HR_DETECT && HR_BIT_COUNT <= DETECT_WINDOW |=> HARD_RESET_VALID)
        else $error("hard reset inside window not accepted");
    hr_reject_a: assert property (HR_DETECT && HR_BIT_COUNT > DETECT_WINDOW |=> !HARD_RESET_VALID)
        else $error("hard reset outside window accepted");
    win_write_a: assert property (wtake && ix == `PRSC_IDX_HR_WINDOW |=> DETECT_WINDOW == $past(DAT_I[6:0]))
        else $error("detect window not written");
    dup_drop_a: assert property (RX_DUP_PKT && AUTO_RESPONSE |=> PKT_DROP)
        else $error("duplicate not dropped");
    size_drop_a: assert property (RX_PKT_END && RX_PKT_LEN > SIZE_LIMIT |=> PKT_DROP)
        else $error("oversize packet not dropped");
    no_drop_a: assert property (!RX_DUP_PKT && !RX_PKT_END |=> !PKT_DROP)
        else $error("drop without cause");
    reset_val_a: assert property ($rose(RST_N) |-> DETECT_WINDOW == 7'h5e && SIZE_LIMIT == 8'h22)
        else $error("window or size limit not at reset value");
    ptr_hold_a: assert property (wtake && ix == `PRSC_IDX_READ_POINTER && !RD_ADVANCE |=> $stable(READ_POINTER))
        else $error("live pointer changed by pointer write");
    forget_all_a: assert property (wtake && ix == `PRSC_IDX_RESET_CONTROL_REGISTER && DAT_I[1:0] != 2'b00
                                   && MSG_ID_STORE == 5'h00 |=> MSG_ID_FORGET == 5'h1f)
        else $error("reset command did not forget ids");
    forget_bit_a: assert property (wtake && ix == `PRSC_IDX_MSG_ID_FLAGS && MSG_ID_STORE == 5'h00
                                   |=> MSG_ID_FORGET == $past(DAT_I[4:0]))
        else $error("flag write did not forget matching ids");
    ctl_write_a: assert property (wtake && ix == `PRSC_IDX_CONTROL
                                  |=> {BIST_RX_TEST, AUTO_RETRY, AUTO_RESPONSE} == $past(DAT_I[2:0]))
        else $error("control bits not written");
    rst_pulse_a: assert property (wtake && ix == `PRSC_IDX_RESET_CONTROL_REGISTER
                                  |=> SOFTWARE_RESET == $past(DAT_I[0]) && PROTOCOL_RESET == $past(DAT_I[1]))
        else $error("reset command pulse wrong");
    rst_idle_a: assert property (!wtake |=> !SOFTWARE_RESET && !PROTOCOL_RESET)
        else $error("reset command pulse without write");
endmodule

bind prsc_rx_status prsc_rx_status_chk i_chk (.*);

//--- tb/prsc_pd_partner.sv
`timescale 1ns/1ps

// ****************************************************************
// port partner: receive events seen on the line
// ****************************************************************
module prsc_pd_partner (
    input  logic        CLOCK,
    output logic        RX_BAD_PKT,
    output logic        RX_DUP_PKT,
    output logic        RX_PKT_END,
    output logic [7:0]  RX_PKT_LEN,
    output logic        RX_ACK_MSG_VALID,
    output logic [15:0] RX_ACK_MSG,
    output logic [4:0]  MSG_ID_STORE,
    output logic        HR_DETECT,
    output logic [6:0]  HR_BIT_COUNT
);
    // quiet line at start
    initial begin
        {RX_BAD_PKT, RX_DUP_PKT, RX_PKT_END, RX_ACK_MSG_VALID, HR_DETECT} = 5'h00;
        {RX_PKT_LEN, RX_ACK_MSG, HR_BIT_COUNT} = 31'h0;
        MSG_ID_STORE = 5'h00;
    end
    // one event: 0 bad, 1 dup, 2 end, 3 ack msg, 4 id store, 5 hard reset
    task automatic send(input int k, input logic [15:0] v);
        begin
            case (k)
                0: RX_BAD_PKT <= 1'b1;
                1: RX_DUP_PKT <= 1'b1;
                2: begin
                    RX_PKT_END <= 1'b1;
                    RX_PKT_LEN <= v[7:0];
                end
                3: begin
                    RX_ACK_MSG_VALID <= 1'b1;
                    RX_ACK_MSG <= v;
                end
                4: MSG_ID_STORE <= v[4:0];
                default: begin
                    HR_DETECT <= 1'b1;
                    HR_BIT_COUNT <= v[6:0];
                end
            endcase
            @(posedge CLOCK);
            {RX_BAD_PKT, RX_DUP_PKT, RX_PKT_END, RX_ACK_MSG_VALID, HR_DETECT} <= 5'h00;
            MSG_ID_STORE <= 5'h00;
            // released data lines must not keep their old value
            RX_PKT_LEN <= ~RX_PKT_LEN;
            RX_ACK_MSG <= ~RX_ACK_MSG;
            HR_BIT_COUNT <= ~HR_BIT_COUNT;
            @(posedge CLOCK);
        end
    endtask
endmodule

//--- tb/tb_prsc_rx_status.sv
`timescale 1ns/1ps

module tb_prsc_rx_status;
    // port-named nets so instances connect by name
    logic        CLOCK = 1'b0, RST_N = 1'b0, WE_I = 1'b0, CYC_I = 1'b0, RD_ADVANCE = 1'b0, FIFO_EMPTY = 1'b1;
    logic [15:0] ADR_I = 16'h0000;
    logic [31:0] DAT_I = 32'h0, DAT_O;
    logic [3:0]  SEL_I = 4'hf;
    wire         STB_I = CYC_I;
    logic        ACK_O, IRQ, PKT_DROP, HARD_RESET_VALID, READ_WRAP, AUTO_RESPONSE, AUTO_RETRY, BIST_RX_TEST;
    logic        SOFTWARE_RESET, PROTOCOL_RESET, RX_BAD_PKT, RX_DUP_PKT, RX_PKT_END, RX_ACK_MSG_VALID, HR_DETECT;
    logic [7:0]  SIZE_LIMIT, RX_PKT_LEN;
    logic [6:0]  DETECT_WINDOW, READ_POINTER, HR_BIT_COUNT;
    logic [4:0]  MSG_ID_FORGET, MSG_ID_STORE;
    logic [15:0] RX_ACK_MSG;
    int          fail_count = 0;
    int          samples_checked = 0;
    prsc_rx_status  i_dut (.*);
    prsc_pd_partner i_peer (.*);
    always #2.5 CLOCK = ~CLOCK;
    task automatic print_verdict;
        begin
            $display("checks %0d mismatches %0d", samples_checked, fail_count);
            if (fail_count == 0 && samples_checked > 0) begin
                $display("bench passed");
            end else begin
                $display("bench failed");
            end
            $finish;
        end
    endtask
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        begin
            samples_checked++;
            if (seen !== exp) begin
                fail_count++;
                $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
            end
        end
    endtask
    // classic single cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [13:0] ix, input logic [7:0] d, output logic [7:0] q);
        int n;
        begin
            n = 0;
            CYC_I <= 1'b1;
            WE_I <= w;
            ADR_I <= {ix, 2'b00};
            DAT_I <= {24'h000000, d};
            @(posedge CLOCK);
            while (ACK_O !== 1'b1 && n < 20) begin
                n++;
                @(posedge CLOCK);
            end
            if (n == 20) fail_count++;
            q = DAT_O[7:0];
            CYC_I <= 1'b0;
            @(posedge CLOCK);
        end
    endtask
    task automatic wr(input logic [13:0] ix, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, ix, d, q);
    endtask
    task automatic rc(input string name, input logic [13:0] ix, input logic [7:0] exp);
        logic [7:0] q;
        begin
            wb(1'b0, ix, 8'h00, q);
            chk(name, q, exp);
        end
    endtask
    task automatic t_reset;
        logic [13:0] ix [9] = '{14'h1a47, 14'h1a48, 14'h1a49, 14'h1a4a, 14'h1a4b, 14'h1a4c, 14'h1a4d, 14'h1a50, 14'h1a4e};
        logic [7:0]  ex [9] = '{8'h00, 8'h00, 8'h5e, 8'h00, 8'h00, 8'h00, 8'h22, 8'h00, 8'h00};
        begin
            for (int i = 0; i < 9; i++) rc("reset value", ix[i], ex[i]);
            wr(14'h1a4a, 8'hff);
            rc("ack high read only", 14'h1a4a, 8'h00);
            wr(14'h1a4e, 8'hff);
            rc("unmapped", 14'h1a4e, 8'h00);
        end
    endtask
    task automatic t_bad;
        repeat (3) i_peer.send(0, 16'h0);
        rc("bad count", 14'h1a47, 8'h03);
        wr(14'h1a5a, 8'h04);
        i_peer.send(0, 16'h0);
        rc("bad count bist", 14'h1a47, 8'h03);
        wr(14'h1a5a, 8'h00);
        wr(14'h1a47, 8'h5a);
        rc("bad count cleared", 14'h1a47, 8'h00);
    endtask
    task automatic t_sat;
        repeat (127) i_peer.send(0, 16'h0);
        wr(14'h1a58, 8'h07);
        rc("irq status at 127", 14'h1a58, 8'h00);
        i_peer.send(0, 16'h0);
        rc("irq status at 128", 14'h1a58, 8'h03);
        repeat (128) i_peer.send(0, 16'h0);
        rc("bad count held", 14'h1a47, 8'hff);
        wr(14'h1a59, 8'h01);
        chk("irq raised", IRQ, 8'h01);
        wr(14'h1a47, 8'h00);
        wr(14'h1a58, 8'h07);
        chk("irq cleared", IRQ, 8'h00);
    endtask
    task automatic t_drop;
        i_peer.send(1, 16'h0);
        rc("dup count off", 14'h1a48, 8'h00);
        wr(14'h1a5a, 8'h01);
        i_peer.send(1, 16'h0);
        rc("dup count", 14'h1a48, 8'h01);
        rc("packet status dup", 14'h1a45, 8'h02);
        rc("irq status dup", 14'h1a58, 8'h04);
        wr(14'h1a45, 8'hff);
        wr(14'h1a58, 8'hff);
        wr(14'h1a4d, 8'h10);
        rc("size limit", 14'h1a4d, 8'h10);
        i_peer.send(2, 16'h0010);
        rc("packet status fit", 14'h1a45, 8'h00);
        i_peer.send(2, 16'h0011);
        rc("packet status over", 14'h1a45, 8'h08);
        rc("irq status over", 14'h1a58, 8'h02);
        rc("bad count over", 14'h1a47, 8'h00);
    endtask
    task automatic t_msg;
        i_peer.send(3, 16'h1234);
        rc("ack high off", 14'h1a4a, 8'h00);
        wr(14'h1a5a, 8'h02);
        i_peer.send(3, 16'ha55a);
        rc("ack high", 14'h1a4a, 8'ha5);
        rc("ack low", 14'h1a4b, 8'h5a);
        i_peer.send(4, 16'h0015);
        rc("id flags", 14'h1a4c, 8'h15);
        wr(14'h1a4c, 8'h01);
        rc("id flags w1c", 14'h1a4c, 8'h14);
        wr(14'h1a5b, 8'h02);
        rc("id flags protocol_reset_command", 14'h1a4c, 8'h00);
        i_peer.send(4, 16'h000a);
        wr(14'h1a5b, 8'h01);
        rc("id flags software_reset_command", 14'h1a4c, 8'h00);
    endtask
    task automatic t_hr_ptr;
        wr(14'h1a49, 8'h20);
        i_peer.send(5, 16'h0020);
        chk("hard reset in window", HARD_RESET_VALID, 8'h01);
        i_peer.send(5, 16'h0021);
        chk("hard reset past window", HARD_RESET_VALID, 8'h00);
        wr(14'h1a50, 8'h05);
        chk("pointer held", READ_POINTER, 8'h00);
        wr(14'h1a51, 8'h01);
        chk("pointer loaded", READ_POINTER, 8'h05);
        chk("wrap output", READ_WRAP, 8'h01);
        RD_ADVANCE <= 1'b1;
        @(posedge CLOCK);
        RD_ADVANCE <= 1'b0;
        rc("pointer advanced", 14'h1a50, 8'h06);
        rc("control bits", 14'h1a51, 8'h81);
    endtask
    // main sequence after 20 cycles of reset
    initial begin
        repeat (20) @(posedge CLOCK);
        RST_N <= 1'b1;
        @(posedge CLOCK);
        t_reset;
        t_bad;
        t_sat;
        t_drop;
        t_msg;
        t_hr_ptr;
        print_verdict;
    end
    // watchdog, about seven times the expected run
    initial begin
        repeat (5000) @(posedge CLOCK);
        fail_count++;
        print_verdict;
    end
endmodule
